/* File: sdc_top.sv */
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - decay selects 1,Z: slow rising, 12.5% mixed falling; both 1: fast falling.
// - only three decay settings use mixed decay while current rises.
// - adaptive enable is sampled only when leaving sleep.
// - adaptive: drive longer than blanking gives slow decay.
// - adaptive overshoot: fast one blank, then two, then quarter off time.
// - adaptive undershoot: slow decay until current trips again.
// - sense ignored during blanking, which is also the minimum drive time.
// - blanking table for sine codes 8 to 31 per torque setting.
// - blanking for sine codes 0 to 7 per torque setting.
// - lasting transistor current limit shuts that bridge and asserts fault.
// - after overcurrent, wait retry time, then drive and release fault.
// - overcurrent is per bridge, both switch sides, independent of sense.
// - overheating disables bridges and faults; release after restart.
// - undervoltage resets logic and holds fault until operation resumes.
// - sleep request low: wait entry time, then regulator, indexer, bridges off.
// - after wake request outputs hold until wake time elapses.
// - output enable high disables bridges; logic keeps running.
// - off time 20, 10 or 30 us for low, Z, high select.
// - mixed decay starts fast, then slow for rest of off time.
// - decay select table for the remaining seven combinations.
module sdc_top
  import sdc_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_US * CLK_MHZ, // wake delay
  parameter int RETRY_CYC = RETRY_US * CLK_MHZ // overcurrent retry delay
) (
  input wire logic ref_clk, // 100 MHz timebase
  input wire logic rst_n, // sync reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb unmapped address
  input wire logic [1:0] winding_sense_input, // sense trip b,a
  input wire logic [1:0] fet_limit_a, // bridge a current limits
  input wire logic [1:0] fet_limit_b, // bridge b current limits
  input wire logic die_hot, // thermal comparator
  input wire logic below_supply_low, // supply under threshold
  output logic [1:0] bridge_a_drive, // bridge a state
  output logic [1:0] bridge_b_drive, // bridge b state
  output logic fault_output_n, // fault, low active
  output logic internal_regulator_on, // regulator enable
  output logic indexer_on // indexer enable
);
  sdc_top_t s_q, s_d;
  sdc_tri_t d0, d1, tf, i0, i1;
  logic [3:0] tq;
  logic [11:0] to;
  logic [1:0] shut, en;
  logic adapt_on, run_ok;
  logic [31:0] stat_w;

  assign d0 = tri_dec(s_q.ctrl.decay_select_low);
  assign d1 = tri_dec(s_q.ctrl.decay_select_high);
  assign tf = tri_dec(s_q.ctrl.toff);
  assign i0 = tri_dec(s_q.ctrl.i0);
  assign i1 = tri_dec(s_q.ctrl.i1);
  assign tq = torque_idx(i1, i0);
  assign to = off_cyc(tf);
  // adaptive only with both selects high
  assign adapt_on = s_q.adaptive && d1 == TRI_HIGH && d0 == TRI_HIGH;

  sdc_ocp #(.RETRY_CYC(RETRY_CYC)) u_ocp_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fet_limit(fet_limit_a),
    .shut(shut[0])
  );
  sdc_ocp #(.RETRY_CYC(RETRY_CYC)) u_ocp_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fet_limit(fet_limit_b),
    .shut(shut[1])
  );

  // enable gates outputs only; torque 11 means outputs off
  assign run_ok = (s_q.mode == M_RUN || s_q.mode == M_ENTER) && !s_q.ctrl.oe_n &&
                  !s_q.hot_s && !s_q.uv_s && tq != TORQUE_OFF;
  assign en = {run_ok && !shut[1], run_ok && !shut[0]};

  assign stat_w = {16'h0000, s_q.ch[1].ovs, s_q.ch[0].ovs, s_q.uvf, s_q.tsd, shut,
                   s_q.ch[1].drv, s_q.ch[0].drv, s_q.adaptive, s_q.mode, s_q.fault_n};

  // fast part of the fixed decay for the selected mode and current direction
  function automatic logic [11:0] fixed_fast(input sdc_tri_t h, input sdc_tri_t l,
                                             input logic rise, input logic [11:0] tb);
    fixed_fast = 12'h000;
    unique case ({h, l})
      // rows with low high select, and rising rows
      {TRI_LOW, TRI_LOW}: fixed_fast = 12'h000;
      {TRI_LOW, TRI_Z}: fixed_fast = rise ? 12'h000 : to >> 2;
      {TRI_LOW, TRI_HIGH}: fixed_fast = rise ? 12'h000 : tb;
      {TRI_Z, TRI_LOW}: fixed_fast = tb;
      {TRI_Z, TRI_Z}: fixed_fast = to >> 1;
      {TRI_Z, TRI_HIGH}: fixed_fast = to >> 2;
      {TRI_HIGH, TRI_LOW}: fixed_fast = rise ? 12'h000 : to >> 1;
      {TRI_HIGH, TRI_Z}: fixed_fast = rise ? 12'h000 : to >> 3;
      {TRI_HIGH, TRI_HIGH}: fixed_fast = rise ? 12'h000 : to;
      default: fixed_fast = 12'h000;
    endcase
  endfunction : fixed_fast

  always_comb begin
    logic [11:0] tb;
    logic rise;
    logic start;
    logic over;
    logic [1:0] on;
    tb = BLANK_A_CYC;
    rise = 1'b0;
    start = 1'b0;
    over = 1'b0;
    on = 2'h0;
    s_d = s_q;
    // comparator pins pass two flops
    s_d.sense_m = winding_sense_input;
    s_d.sense_s = s_q.sense_m;
    s_d.hot_m = die_hot;
    s_d.hot_s = s_q.hot_m;
    s_d.uv_m = below_supply_low;
    s_d.uv_s = s_q.uv_m;

    // apb: answer one cycle into access, commit on the completing edge
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      unique case (paddr)
        ADDR_CTRL: s_d.prdata = s_q.ctrl;
        ADDR_PHASE: s_d.prdata = s_q.ph;
        ADDR_STAT: s_d.prdata = stat_w;
        default: begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        s_d.ctrl = pwdata;
      end
      if (paddr == ADDR_PHASE) begin
        s_d.ph = pwdata;
      end
    end

    // operating mode sequencing
    unique case (s_q.mode)
      M_SLEEP: begin
        if (s_q.ctrl.sleep_n) begin
          s_d.mode = M_WAKE;
          s_d.mcnt = 17'(WAKE_CYC - 1);
          s_d.adaptive = s_q.ctrl.adaptive_decay_enable;
        end
      end
      M_WAKE: begin
        // bridges stay off until wake time ends
        if (!s_q.ctrl.sleep_n) begin
          s_d.mode = M_SLEEP;
        end else if (s_q.mcnt == 17'h0) begin
          s_d.mode = M_RUN;
        end else begin
          s_d.mcnt = s_q.mcnt - 17'h1;
        end
      end
      M_RUN: begin
        if (!s_q.ctrl.sleep_n) begin
          s_d.mode = M_ENTER;
          s_d.mcnt = SLEEP_CYC - 17'h1;
        end
      end
      M_ENTER: begin
        // keep running for the entry time
        if (s_q.ctrl.sleep_n) begin
          s_d.mode = M_RUN;
        end else if (s_q.mcnt == 17'h0) begin
          s_d.mode = M_SLEEP;
        end else begin
          s_d.mcnt = s_q.mcnt - 17'h1;
        end
      end
    endcase

    // per-bridge chopper
    for (int b = 0; b < 2; b++) begin
      tb = blank_cyc(b == 1 ? s_q.ph.sine_b : s_q.ph.sine_a, tq);
      rise = b == 1 ? s_q.ph.rise_b : s_q.ph.rise_a;
      start = 1'b0;
      over = 1'b0;
      unique case (s_q.ch[b].st)
        C_IDLE: begin
          if (en[b]) begin
            s_d.ch[b].st = C_BLANK;
            s_d.ch[b].cnt = tb;
          end
        end
        C_BLANK: begin
          // sense looked at only once blanking ends
          if (s_q.ch[b].cnt > 12'h001) begin
            s_d.ch[b].cnt = s_q.ch[b].cnt - 12'h001;
          end else if (s_q.sense_s[b]) begin
            start = 1'b1;
            over = 1'b1;
          end else begin
            s_d.ch[b].st = C_DRIVE;
          end
        end
        C_DRIVE: begin
          if (s_q.sense_s[b]) begin
            start = 1'b1;
          end
        end
        C_DECAY: begin
          // fast portion first, slow for the rest
          if (s_q.ch[b].fast != 12'h000) begin
            s_d.ch[b].fast = s_q.ch[b].fast - 12'h001;
          end
          if (s_q.ch[b].cnt > 12'h001) begin
            s_d.ch[b].cnt = s_q.ch[b].cnt - 12'h001;
          end else begin
            s_d.ch[b].st = C_BLANK;
            s_d.ch[b].cnt = tb;
          end
        end
      endcase
      if (start) begin
        s_d.ch[b].st = C_DECAY;
        s_d.ch[b].cnt = to;
        if (adapt_on) begin
          // saturating overshoot count, cleared on undershoot
          on = !over ? 2'h0 : s_q.ch[b].ovs == 2'h3 ? 2'h3 : s_q.ch[b].ovs + 2'h1;
          s_d.ch[b].ovs = on;
          s_d.ch[b].fast = on == 2'h0 ? 12'h000 : on == 2'h1 ? tb :
                           on == 2'h2 ? 12'(tb << 1) : to >> 2;
        end else begin
          s_d.ch[b].fast = fixed_fast(d1, d0, rise, tb);
        end
      end
      // off on the edge that enters sleep, with the regulator
      if (!en[b] || s_d.mode == M_SLEEP) begin
        s_d.ch[b] = '0;
      end
      s_d.ch[b].drv = s_d.ch[b].st == C_IDLE ? BR_OFF :
                      s_d.ch[b].st != C_DECAY ? BR_DRIVE :
                      s_d.ch[b].fast != 12'h000 ? BR_FAST : BR_SLOW;
    end

    // regulator and indexer off in sleep
    s_d.reg_on = s_d.mode != M_SLEEP;
    s_d.idx_on = s_d.mode != M_SLEEP;
    // thermal fault lags the restart by a cycle
    s_d.tsd = s_q.hot_s;
    // undervoltage resets logic, fault held until running again
    if (s_q.uv_s) begin
      s_d.uvf = 1'b1;
      s_d.mode = M_SLEEP;
      s_d.adaptive = 1'b0;
      s_d.mcnt = 17'h0;
      s_d.ch = '0;
      s_d.reg_on = 1'b0;
      s_d.idx_on = 1'b0;
    end else if (s_q.mode == M_RUN) begin
      s_d.uvf = 1'b0;
    end
    // fault is unlatched and follows its causes
    s_d.fault_n = !(s_q.uv_s || s_q.uvf || s_q.hot_s || s_q.tsd || |shut);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.ph <= PHASE_RST;
      s_q.fault_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign bridge_a_drive = s_q.ch[0].drv;
  assign bridge_b_drive = s_q.ch[1].drv;
  assign fault_output_n = s_q.fault_n;
  assign internal_regulator_on = s_q.reg_on;
  assign indexer_on = s_q.idx_on;

  a_hot_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.hot_s |=> !fault_output_n && bridge_a_drive == BR_OFF)
    else $error("overheat did not fault and stop bridge");
  a_uv_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.uv_s |=> !fault_output_n && !internal_regulator_on)
    else $error("undervoltage did not fault");
  a_sleep_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.mode == M_SLEEP |-> !internal_regulator_on && !indexer_on &&
      bridge_a_drive == BR_OFF && bridge_b_drive == BR_OFF)
    else $error("sleep left something on");
  a_wake_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.mode == M_WAKE |-> bridge_a_drive == BR_OFF && bridge_b_drive == BR_OFF)
    else $error("outputs changed during wake time");
  a_oe_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.ctrl.oe_n |=> bridge_a_drive == BR_OFF && bridge_b_drive == BR_OFF)
    else $error("disabled bridge still driving");
  a_blank_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.ch[0].st == C_BLANK && s_q.ch[0].cnt > 12'h001 && en[0] && s_q.mode == M_RUN)
      |=> bridge_a_drive == BR_DRIVE)
    else $error("sense acted inside blanking");
  a_adapt_slow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (adapt_on && en[0] && s_q.mode == M_RUN && s_q.ch[0].st == C_DRIVE && s_q.sense_s[0])
      |=> bridge_a_drive == BR_SLOW && s_q.ch[0].ovs == 2'h0)
    else $error("long drive not followed by slow decay");
  a_adaptive_decay_enable_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($changed(s_q.adaptive) && !$past(s_q.uv_s)) |-> $past(s_q.mode) == M_SLEEP)
    else $error("adaptive enable sampled outside sleep exit");
  a_adapt_escalate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (adapt_on && en[0] && s_q.mode == M_RUN && s_q.ch[0].st == C_BLANK &&
      s_q.ch[0].cnt == 12'h001 && s_q.sense_s[0] && s_q.ch[0].ovs == 2'h0)
      |=> bridge_a_drive == BR_FAST && s_q.ch[0].ovs == 2'h1)
    else $error("first overshoot not followed by fast decay");
  a_ocp_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |shut |=> !fault_output_n)
    else $error("overcurrent shutdown did not assert fault");
endmodule : sdc_top
`default_nettype wire

/* File: sdc_pkg.sv */
`default_nettype none
package sdc_pkg;
  // decoded tri-level pin, bridge output state and machine states
  typedef enum logic [1:0] {TRI_LOW, TRI_Z, TRI_HIGH} sdc_tri_t;
  typedef enum logic [1:0] {BR_OFF, BR_DRIVE, BR_FAST, BR_SLOW} sdc_drv_t;
  typedef enum logic [1:0] {C_IDLE, C_BLANK, C_DRIVE, C_DECAY} sdc_cst_t;
  typedef enum logic [1:0] {M_SLEEP, M_WAKE, M_RUN, M_ENTER} sdc_mode_t;
  typedef enum logic {O_OK, O_SHUT} sdc_ost_t;

  // timebase
  localparam int CLK_MHZ = 100;
  localparam int BLANK_A_NS = 900;
  localparam int BLANK_B_NS = 1200;
  localparam int BLANK_C_NS = 1500;
  localparam int BLANK_D_NS = 1800;
  localparam logic [11:0] BLANK_A_CYC = 12'(BLANK_A_NS * CLK_MHZ / 1000);
  localparam logic [11:0] BLANK_B_CYC = 12'(BLANK_B_NS * CLK_MHZ / 1000);
  localparam logic [11:0] BLANK_C_CYC = 12'(BLANK_C_NS * CLK_MHZ / 1000);
  localparam logic [11:0] BLANK_D_CYC = 12'(BLANK_D_NS * CLK_MHZ / 1000);
  localparam int TOFF_LOW_US = 20;
  localparam int TOFF_Z_US = 10;
  localparam int TOFF_HIGH_US = 30;
  localparam logic [11:0] TOFF_LOW_CYC = 12'(TOFF_LOW_US * CLK_MHZ);
  localparam logic [11:0] TOFF_Z_CYC = 12'(TOFF_Z_US * CLK_MHZ);
  localparam logic [11:0] TOFF_HIGH_CYC = 12'(TOFF_HIGH_US * CLK_MHZ);
  localparam int OCP_DEGLITCH_NS = 3000;
  localparam logic [16:0] OCP_CYC = 17'(OCP_DEGLITCH_NS * CLK_MHZ / 1000);
  localparam int SLEEP_US = 1;
  localparam logic [16:0] SLEEP_CYC = 17'(SLEEP_US * CLK_MHZ);
  localparam int WAKE_US = 1000;
  localparam int RETRY_US = 1000;
  localparam logic [3:0] TORQUE_OFF = 4'h8;

  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PHASE_RST = 32'h0000_0000;

  typedef struct packed {
    logic [18:0] rsvd;
    logic oe_n;
    logic sleep_n;
    logic adaptive_decay_enable;
    logic [1:0] i1;
    logic [1:0] i0;
    logic [1:0] toff;
    logic [1:0] decay_select_high;
    logic [1:0] decay_select_low;
  } sdc_ctrl_t;

  typedef struct packed {
    logic [13:0] rsvd;
    logic rise_b;
    logic rise_a;
    logic [2:0] r1;
    logic [4:0] sine_b;
    logic [2:0] r0;
    logic [4:0] sine_a;
  } sdc_phase_t;

  typedef struct packed {
    sdc_cst_t st;
    logic [11:0] cnt;
    logic [11:0] fast;
    logic [1:0] ovs;
    sdc_drv_t drv;
  } sdc_chop_t;

  typedef struct packed {
    sdc_ctrl_t ctrl;
    sdc_phase_t ph;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sdc_mode_t mode;
    logic [16:0] mcnt;
    logic adaptive;
    logic [1:0] sense_m;
    logic [1:0] sense_s;
    logic hot_m;
    logic hot_s;
    logic uv_m;
    logic uv_s;
    logic tsd;
    logic uvf;
    logic fault_n;
    logic reg_on;
    logic idx_on;
    sdc_chop_t [1:0] ch;
  } sdc_top_t;

  typedef struct packed {
    logic [1:0] lim_m;
    logic [1:0] lim_s;
    sdc_ost_t st;
    logic [16:0] cnt;
    logic shut;
  } sdc_ocp_t;

  // 00 low, 10 high, open pin reads as Z; 11 cannot occur, taken as Z
  function automatic sdc_tri_t tri_dec(input logic [1:0] c);
    unique case (c)
      2'h0: tri_dec = TRI_LOW;
      2'h2: tri_dec = TRI_HIGH;
      default: tri_dec = TRI_Z;
    endcase
  endfunction : tri_dec

  // torque setting 00,0Z,01,Z0,ZZ,Z1,10,1Z,11 as 0..8
  function automatic logic [3:0] torque_idx(input sdc_tri_t hi, input sdc_tri_t lo);
    torque_idx = 4'(3 * int'(hi) + int'(lo));
  endfunction : torque_idx

  function automatic logic [11:0] blank_cyc(input logic [4:0] sine, input logic [3:0] t);
    if (sine >= 5'h10) begin
      blank_cyc = t < 4'h2 ? BLANK_D_CYC : t < 4'h5 ? BLANK_C_CYC :
                  t < 4'h7 ? BLANK_B_CYC : BLANK_A_CYC;
    end else if (sine >= 5'h08) begin
      blank_cyc = t < 4'h3 ? BLANK_C_CYC : t < 4'h6 ? BLANK_B_CYC : BLANK_A_CYC;
    end else if (sine >= 5'h04) begin
      blank_cyc = t < 4'h3 ? BLANK_B_CYC : BLANK_A_CYC;
    end else begin
      blank_cyc = BLANK_A_CYC;
    end
  endfunction : blank_cyc

  function automatic logic [11:0] off_cyc(input sdc_tri_t s);
    unique case (s)
      TRI_LOW: off_cyc = TOFF_LOW_CYC;
      TRI_HIGH: off_cyc = TOFF_HIGH_CYC;
      default: off_cyc = TOFF_Z_CYC;
    endcase
  endfunction : off_cyc
endpackage : sdc_pkg
`default_nettype wire

/* File: sdc_ocp.sv */
`timescale 1ns/100ps
`default_nettype none
module sdc_ocp
  import sdc_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_US * CLK_MHZ
) (
  input wire logic ref_clk, // timebase
  input wire logic rst_n, // sync reset
  input wire logic [1:0] fet_limit, // high/low side limit, async
  output logic shut // bridge held off
);
  sdc_ocp_t s_q, s_d;

  // deglitch then hold off for the retry time
  always_comb begin
    s_d = s_q;
    s_d.lim_m = fet_limit;
    s_d.lim_s = s_q.lim_m;
    unique case (s_q.st)
      O_OK: begin
        if (|s_q.lim_s) begin
          if (s_q.cnt == OCP_CYC - 17'h1) begin
            s_d.st = O_SHUT;
            s_d.cnt = '0;
          end else begin
            s_d.cnt = s_q.cnt + 17'h1;
          end
        end else begin
          s_d.cnt = '0;
        end
      end
      O_SHUT: begin
        if (s_q.cnt == 17'(RETRY_CYC - 1)) begin
          s_d.st = O_OK;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 17'h1;
        end
      end
    endcase
    s_d.shut = s_d.st == O_SHUT;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign shut = s_q.shut;

  a_ocp_trip: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == O_OK && s_q.cnt == OCP_CYC - 17'h1 && |s_q.lim_s) |=> shut)
    else $error("overcurrent did not shut bridge");
  a_retry_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(shut) |-> shut [*8])
    else $error("bridge released before retry time");
endmodule : sdc_ocp
`default_nettype wire

/* File: sdc_motor.sv */
`timescale 1ns/100ps
`default_nettype none
module sdc_motor
  import sdc_pkg::*;
(
  input wire logic ref_clk, // timebase
  input wire logic rst_n, // sync reset, low
  input wire logic [1:0] bridge_a_drive, // bridge a state
  input wire logic [1:0] bridge_b_drive, // bridge b state
  input wire logic [11:0] trip_level, // current counts at which sense trips
  output logic [1:0] winding_sense_input // sense trip b,a
);
  logic [11:0] cur_q [2];

  // winding current ramps up while driven and drains in decay or off
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!rst_n) begin
        cur_q[k] <= 12'h000;
      end else if ((k == 0 ? bridge_a_drive : bridge_b_drive) == BR_DRIVE) begin
        cur_q[k] <= cur_q[k] + 12'h001;
      end else if (cur_q[k] != 12'h000) begin
        cur_q[k] <= cur_q[k] - 12'h001;
      end
    end
  end

  // comparator only; a low trip level makes every drive overshoot
  assign winding_sense_input = {cur_q[1] >= trip_level, cur_q[0] >= trip_level};
endmodule : sdc_motor
`default_nettype wire

/* File: stepper_chopper_decay_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module stepper_chopper_decay_control_tb_top;
  import sdc_pkg::*;
  localparam int WAKE_N = 20;
  localparam int RETRY_N = 16;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] sense;
  logic [1:0] lim_a = 2'h0;
  logic [1:0] lim_b = 2'h0;
  logic hot = 1'b0;
  logic uv = 1'b0;
  logic [1:0] br_a;
  logic [1:0] br_b;
  logic fault_n;
  logic reg_on;
  logic idx_on;
  logic [11:0] trip = 12'h001;
  logic [11:0] dl = 12'h000;
  logic [11:0] fc = 12'h000;
  logic [11:0] tc = 12'h000;
  logic [11:0] gd;
  logic [11:0] gf;
  logic [11:0] gt;
  logic [1:0] pd = 2'h0;
  logic [35:0] q[$];
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int cmp_count = 0;
  int wd = 0;

  sdc_top #(.WAKE_CYC(WAKE_N), .RETRY_CYC(RETRY_N)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .winding_sense_input(sense), .fet_limit_a(lim_a), .fet_limit_b(lim_b), .die_hot(hot),
    .below_supply_low(uv), .bridge_a_drive(br_a), .bridge_b_drive(br_b),
    .fault_output_n(fault_n), .internal_regulator_on(reg_on), .indexer_on(idx_on));

  sdc_motor u_motor (.ref_clk(ref_clk), .rst_n(rst_n), .bridge_a_drive(br_a),
    .bridge_b_drive(br_b), .trip_level(trip), .winding_sense_input(sense));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // pin codes 0 low, 1 Z, 2 high; torque index 0..7 splits into two pins
  function automatic logic [31:0] ctrl(int d0, int d1, int tf, int tq, int ad, int sl, int oe);
    ctrl = 32'(oe * 4096 + sl * 2048 + ad * 1024 + (tq / 3) * 256 + (tq % 3) * 64 + tf * 16
      + d1 * 4 + d0);
  endfunction : ctrl

  function automatic int bexp(int s, int t);
    int r[4][8] = '{'{90, 90, 90, 90, 90, 90, 90, 90}, '{120, 120, 120, 90, 90, 90, 90, 90},
      '{150, 150, 150, 120, 120, 120, 90, 90}, '{180, 180, 150, 150, 150, 120, 120, 90}};
    bexp = r[s >= 16 ? 3 : s >= 8 ? 2 : s >= 4 ? 1 : 0][t];
  endfunction : bexp

  // fast part of a fixed decay, by decay code high*3+low
  function automatic int fexp(int c, int rs, int tb, int off);
    int f[9] = '{0, off / 4, tb, tb, off / 2, off / 4, off / 2, off / 8, off};
    fexp = (rs == 1 && (c < 3 || c > 5)) ? 0 : f[c];
  endfunction : fexp

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // one transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // no cycle limit here; the watchdog ends a hung access
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic per(int k);
    for (int n = 0; n < 20000 && q.size() <= k; n++) @(posedge ref_clk);
    {gd, gf, gt} = q[k];
  endtask : per

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // records drive, fast and total decay length of every chopping period of bridge a
  always @(posedge ref_clk) begin
    wd++;
    if (wd == 90000) begin
      err_count++;
      end_sim();
    end
    if (br_a === 2'h1) begin
      if (pd !== 2'h1) begin
        if (pd === 2'h2 || pd === 2'h3) begin
          q.push_back({dl, fc, tc});
        end
        dl = 12'h000;
        fc = 12'h000;
        tc = 12'h000;
      end
      dl = dl + 12'h001;
    end else if (br_a === 2'h2 || br_a === 2'h3) begin
      tc = tc + 12'h001;
      if (br_a === 2'h2) fc = fc + 12'h001;
    end
    pd = br_a;
  end

  initial begin
    int n, s, t, c;
    void'($urandom(39));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl reset", CTRL_RST, rd);
    apb(1'b0, 8'h0c, 0);
    chk("unmapped error", 1, er);
    chk("fault idle", 1, fault_n);
    apb(1'b1, ADDR_PHASE, 32'h1f1f);
    apb(1'b0, ADDR_PHASE, 0);
    chk("phase readback", 32'h1f1f, rd);
    apb(1'b1, ADDR_CTRL, ctrl(0, 0, 1, 0, 0, 1, 0));
    for (n = 0; n < 1000 && br_a === 2'h0; n++) @(posedge ref_clk);
    chk("wake hold", 1, n >= WAKE_N);
    $display("test reset and wake done");
    for (int i = 0; i < 4; i++) begin
      s = i == 0 ? 16 : i == 1 ? 7 : $urandom % 32;
      t = i == 0 ? 7 : $urandom % 8;
      apb(1'b1, ADDR_PHASE, 32'(s * 257));
      apb(1'b1, ADDR_CTRL, ctrl(0, 0, i % 3, t, 0, 1, 0));
      q.delete();
      per(1);
      chk("blank length", bexp(s, t), gd);
      chk("off time", i % 3 == 0 ? 2000 : i % 3 == 1 ? 1000 : 3000, gt);
      chk("slow only", 0, gf);
    end
    $display("test blanking and off time done");
    for (int j = 0; j < 13; j++) begin
      c = j < 9 ? j : j - 6;
      apb(1'b1, ADDR_PHASE, 32'h1f1f | (j >= 9 ? 32'h1_0000 : 32'h0));
      apb(1'b1, ADDR_CTRL, ctrl(c % 3, c / 3, 1, 0, 0, 1, 0));
      q.delete();
      per(1);
      chk("fast part", fexp(c, j >= 9, 180, 1000), gf);
      chk("decay total", 1000, gt);
    end
    $display("test fixed decay done");
    apb(1'b1, ADDR_CTRL, ctrl(2, 2, 1, 0, 0, 0, 0));
    for (n = 0; n < 500 && reg_on !== 1'b0; n++) @(posedge ref_clk);
    chk("sleep entry", 1, n >= 98 && n <= 102);
    chk("sleep parts", 3'h0, {br_a === 2'h0 ? 1'b0 : 1'b1, idx_on, reg_on});
    apb(1'b1, ADDR_CTRL, ctrl(2, 2, 1, 0, 1, 1, 0));
    q.delete();
    for (int k = 0; k < 4; k++) begin
      per(k);
      chk("adaptive fast", k == 0 ? 180 : k == 1 ? 360 : 250, gf);
    end
    trip <= 12'd200;
    q.delete();
    per(1);
    chk("undershoot slow", 0, gf);
    chk("long drive", 1, gd > 180);
    for (n = 0; n < 5000 && br_a !== 2'h3; n++) @(posedge ref_clk);
    trip <= 12'h001;
    apb(1'b1, ADDR_CTRL, ctrl(2, 2, 1, 0, 0, 1, 0));
    q.delete();
    // entry 0 is the undershoot period still decaying when the trip changed
    per(1);
    chk("count restart", 180, gf);
    $display("test adaptive done");
    apb(1'b1, ADDR_CTRL, ctrl(2, 2, 1, 0, 0, 1, 1));
    repeat (5) @(posedge ref_clk);
    chk("disabled state", 6'h03, {br_a, br_b, idx_on, reg_on});
    apb(1'b1, ADDR_CTRL, ctrl(2, 2, 1, 0, 0, 1, 0));
    for (n = 0; n < 3000 && br_a === 2'h0; n++) @(posedge ref_clk);
    chk("enable resumes", 1, br_a !== 2'h0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) lim_a <= 2'h2;
      else lim_b <= 2'h1;
      for (n = 0; n < 600 && (k == 0 ? br_a : br_b) !== 2'h0; n++) @(posedge ref_clk);
      chk("overcurrent deglitch", 1, n >= 300 && n <= 310);
      repeat (2) @(posedge ref_clk);
      chk("overcurrent fault", 0, fault_n);
      chk("other bridge runs", 1, (k == 0 ? br_b : br_a) !== 2'h0);
      lim_a <= 2'h0;
      lim_b <= 2'h0;
      for (n = 0; n < 200 && fault_n !== 1'b1; n++) @(posedge ref_clk);
      chk("retry time", 1, n >= RETRY_N - 4 && n <= RETRY_N + 8);
      chk("retry drives", 1, (k == 0 ? br_a : br_b) !== 2'h0);
    end
    $display("test overcurrent done");
    hot <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("thermal off", 5'h00, {br_a, br_b, fault_n});
    hot <= 1'b0;
    for (n = 0; n < 50 && fault_n !== 1'b1; n++) @(posedge ref_clk);
    chk("thermal restart", 1, br_a !== 2'h0 && fault_n === 1'b1);
    uv <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("supply low", 7'h00, {br_a, br_b, fault_n, idx_on, reg_on});
    uv <= 1'b0;
    for (n = 0; n < 500 && fault_n !== 1'b1; n++) @(posedge ref_clk);
    chk("supply resume", 1, n >= WAKE_N && n < 500);
    $display("test thermal and supply done");
    end_sim();
  end
endmodule : stepper_chopper_decay_control_tb_top
`default_nettype wire
